// File: design/imw_pkg.sv
// constants, timing and state encoding for the two-wire master sequencer
// assumes a 100 MHz system clock and an open-drain bus pulled up outside
package imw_pkg;

   // system clock and bus bit timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCL_HALF_NS   = 5000;       // half of a 100 kHz bit period
   localparam int HALF_CYC      = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W         = 10;
   localparam logic [TMR_W-1:0] HALF_CNT = TMR_W'(HALF_CYC - 1);
   localparam logic [TMR_W-1:0] TMR_ZERO = 10'h000;

   // byte framing
   localparam int BYTE_W = 8;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST  = 3'h7;
   localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;   // 11110 marks a 10-bit address
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // open-drain pins only ever pull low
   localparam logic PIN_LOW = 1'h0;

   // reset values
   localparam logic SYNC_RST = 1'h1;                // idle bus reads high
   localparam logic FLAG_RST = 1'h0;

   // irq status word bit positions
   localparam int IST_TRANSMIT_DATA_EMPTY_FLAG = 0;
   localparam int IST_RDRF = 1;
   localparam int IST_NO_ACKNOWLEDGE_IRQ_FLAG = 2;
   localparam int IST_W    = 3;

   typedef enum logic [3:0] {
      ST_IDLE, ST_START_A, ST_START_B, ST_LOAD, ST_BIT_L, ST_BIT_H,
      ST_ACK_L, ST_ACK_H, ST_RX_WAIT, ST_WAIT, ST_RS_A,
      ST_STOP_A, ST_STOP_B, ST_STOP_C
   } imw_state_e;

endpackage

// File: design/imw_sync.sv
// two flip-flop synchroniser for bus pin inputs, one stage pair per bit
// assumes inputs are asynchronous to sys_clk; resetn is synchronous, active low
`timescale 1ns/10ps
`default_nettype none
module imw_sync #(
   parameter int W = 2
) (
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_reg;

   // first stage feeds only the second stage
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++)
      begin : g_bit
         always_ff @(posedge sys_clk)
         begin
            if (!resetn)
            begin
               meta_reg[gi] <= imw_pkg::SYNC_RST;
               sync_out[gi] <= imw_pkg::SYNC_RST;
            end
            else
            begin
               meta_reg[gi] <= async_in[gi];
               sync_out[gi] <= meta_reg[gi];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// File: design/imw_master.sv
// master sequencer for two-wire writes and reads, with host-side data register
// assumes host strobes are one-cycle pulses on sys_clk; pins are open drain
//
// Behaviour
// - a 10-bit address starts with 11110 then the two top address bits
// - own slave address width never limits the remote address sent
// - enabled with transmit irq enabled, empty data register raises interrupt
// - start bit gives START, then data register copied into shift register
// - transmit interrupt reasserts once first bit of a byte has left
// - slave pulls SDA low in SCL high; controller records positive acknowledge
// - address not acknowledged: set no-ack flag, ack-valid, clear ack status
// - on address no-ack, flush data, send STOP, clear stop and no-ack; the STOP waits in ST_WAIT for a stop request
// - stop request waits for current byte to finish before STOP
// - data byte not acknowledged: flags as address case, halt, flush data
// - after read address ack, shift in a byte then raise receive interrupt
// - after each received byte drive no-ack if final, else acknowledge
// - after final no-acked byte raise no-ack flag; stop gives STOP
// - transmit empty flag follows the data register regardless of irq enable
`timescale 1ns/10ps
`default_nettype none
module imw_master (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        controller_enable_bit,
   input  wire logic        transmit_irq_enable,
   input  wire logic        start_req,
   input  wire logic        stop_req,
   input  wire logic        negative_ack_ctrl,
   input  wire logic        data_wr,
   input  wire logic [7:0]  data_wdata,
   input  wire logic        data_rd,
   output logic      [7:0]  data_rdata,
   output logic             start_bit,
   output logic             stop_bit,
   output logic             transmit_data_empty_flag,
   output logic             receive_full_flag,
   output logic             no_acknowledge_irq_flag,
   output logic             acknowledge_valid_flag,
   output logic             ack_status,
   output logic             bus_active,
   output logic      [2:0]  irq_status_register,
   output logic             irq,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);

   imw_pkg::imw_state_e      state_reg, state_next;
   logic [imw_pkg::TMR_W-1:0] tmr_reg;
   logic [7:0] shift_reg, dr_reg;
   logic [2:0] bit_cnt_reg;
   logic       dr_full_reg, hold_reg, rdrf_reg, no_acknowledge_irq_flag_reg, acknowledge_valid_flag_reg, ack_reg;
   logic       start_reg, stop_reg, first_reg, addr10_reg, rd_dir_reg;
   logic       rx_reg, halted_reg, nak_sent_reg, scl_oe_reg, sda_oe_reg;
   logic       scl_s, sda_s, done, bit_smp, ack_smp;
   logic       tx_ack_ok, tx_nack, rx_byte_done, rx_nak_done, stop_done, start_done;
   logic       scl_drv, sda_drv;

   // bus pins cross into sys_clk before anything looks at them
   imw_sync #(.W(2)) u_sync (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .async_in ({scl_i, sda_i}),
      .sync_out ({scl_s, sda_s})
   );

   // events decoded from the sequencer
   assign done         = (tmr_reg == imw_pkg::TMR_ZERO);
   assign bit_smp      = (state_reg == imw_pkg::ST_BIT_H) && done && scl_s;
   assign ack_smp      = (state_reg == imw_pkg::ST_ACK_H) && done && scl_s;
   assign tx_ack_ok    = ack_smp && !rx_reg && !sda_s;
   assign tx_nack      = ack_smp && !rx_reg && sda_s;
   assign rx_byte_done = bit_smp && rx_reg && (bit_cnt_reg == imw_pkg::BIT_LAST);
   assign rx_nak_done  = ack_smp && rx_reg && nak_sent_reg;
   assign stop_done    = (state_reg == imw_pkg::ST_STOP_C) && done;
   assign start_done   = (state_reg == imw_pkg::ST_START_B) && done;

   // next state; stop and start only looked at on byte boundaries
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         imw_pkg::ST_IDLE:
            if (controller_enable_bit && start_reg)
               state_next = imw_pkg::ST_START_A;
         imw_pkg::ST_START_A:
            if (done && scl_s)
               state_next = imw_pkg::ST_START_B;
         imw_pkg::ST_START_B:
            if (done)
               state_next = imw_pkg::ST_LOAD;
         imw_pkg::ST_LOAD:
            if (dr_full_reg)
               state_next = imw_pkg::ST_BIT_L;
         imw_pkg::ST_BIT_L:
            if (done)
               state_next = imw_pkg::ST_BIT_H;
         imw_pkg::ST_BIT_H:
            if (bit_smp)
            begin
               if (bit_cnt_reg != imw_pkg::BIT_LAST)
                  state_next = imw_pkg::ST_BIT_L;
               else if (rx_reg)
                  state_next = imw_pkg::ST_RX_WAIT;
               else
                  state_next = imw_pkg::ST_ACK_L;
            end
         imw_pkg::ST_RX_WAIT:
            if (!rdrf_reg)
               state_next = imw_pkg::ST_ACK_L;
         imw_pkg::ST_ACK_L:
            if (done)
               state_next = imw_pkg::ST_ACK_H;
         imw_pkg::ST_ACK_H:
            if (ack_smp)
            begin
               if (tx_nack || rx_nak_done)
                  state_next = imw_pkg::ST_WAIT;
               else if (stop_reg)
                  state_next = imw_pkg::ST_STOP_A;
               else if (start_reg)
                  state_next = imw_pkg::ST_RS_A;
               else if (rd_dir_reg)
                  state_next = imw_pkg::ST_BIT_L;
               else if (dr_full_reg)
                  state_next = imw_pkg::ST_LOAD;
               else
                  state_next = imw_pkg::ST_WAIT;
            end
         imw_pkg::ST_WAIT:
            if (stop_reg)
               state_next = imw_pkg::ST_STOP_A;
            else if (start_reg)
               state_next = imw_pkg::ST_RS_A;
            else if (!halted_reg && dr_full_reg)
               state_next = imw_pkg::ST_LOAD;
         imw_pkg::ST_RS_A:
            if (done)
               state_next = imw_pkg::ST_START_A;
         imw_pkg::ST_STOP_A:
            if (done)
               state_next = imw_pkg::ST_STOP_B;
         imw_pkg::ST_STOP_B:
            if (done && scl_s)
               state_next = imw_pkg::ST_STOP_C;
         imw_pkg::ST_STOP_C:
            if (done)
               state_next = imw_pkg::ST_IDLE;
         default:
            state_next = imw_pkg::ST_IDLE;
      endcase
   end

   // state and phase timer; high phases hold while a slave stretches scl
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         state_reg <= imw_pkg::ST_IDLE;
         tmr_reg   <= imw_pkg::HALF_CNT;
      end
      else
      begin
         state_reg <= state_next;
         if (state_next != state_reg)
            tmr_reg <= imw_pkg::HALF_CNT;
         else if (!done && scl_s)
            tmr_reg <= tmr_reg - 1'b1;
         else if (!done && (scl_oe_reg || state_reg == imw_pkg::ST_RS_A))
            tmr_reg <= tmr_reg - 1'b1;
      end
   end

   // byte shifter, bit counter and direction of the current byte
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         shift_reg    <= imw_pkg::BYTE_ZERO;
         bit_cnt_reg  <= imw_pkg::BIT_FIRST;
         rx_reg       <= imw_pkg::FLAG_RST;
         first_reg    <= imw_pkg::FLAG_RST;
         addr10_reg   <= imw_pkg::FLAG_RST;
         rd_dir_reg   <= imw_pkg::FLAG_RST;
         halted_reg   <= imw_pkg::FLAG_RST;
         nak_sent_reg <= imw_pkg::FLAG_RST;
      end
      else
      begin
         if (start_done)
         begin
            first_reg  <= 1'b1;
            rd_dir_reg <= 1'b0;
            halted_reg <= 1'b0;
         end
         // address goes out exactly as written, whatever our own slave width
         if (state_reg == imw_pkg::ST_LOAD && dr_full_reg)
         begin
            shift_reg   <= dr_reg;
            bit_cnt_reg <= imw_pkg::BIT_FIRST;
            rx_reg      <= 1'b0;
            first_reg   <= 1'b0;
            if (first_reg)
            begin
               rd_dir_reg <= dr_reg[0];
               addr10_reg <= (dr_reg[7:3] == imw_pkg::TEN_BIT_PREFIX);
            end
         end
         if (bit_smp)
         begin
            shift_reg   <= rx_reg ? {shift_reg[6:0], sda_s} : {shift_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
         end
         // after an acked read address every further byte is received
         if (ack_smp && !tx_nack && !rx_nak_done && rd_dir_reg)
         begin
            rx_reg      <= 1'b1;
            bit_cnt_reg <= imw_pkg::BIT_FIRST;
         end
         if (state_reg == imw_pkg::ST_RX_WAIT && !rdrf_reg)
            nak_sent_reg <= negative_ack_ctrl;
         if (tx_nack || rx_nak_done)
            halted_reg <= 1'b1;
      end
   end

   // host data register: write fills, load empties, a no-ack flushes
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         dr_reg      <= imw_pkg::BYTE_ZERO;
         dr_full_reg <= imw_pkg::FLAG_RST;
         hold_reg    <= imw_pkg::FLAG_RST;
         rdrf_reg    <= imw_pkg::FLAG_RST;
      end
      else
      begin
         if (state_reg == imw_pkg::ST_LOAD && dr_full_reg)
         begin
            dr_full_reg <= 1'b0;
            hold_reg    <= 1'b1;
         end
         if (tx_nack)
            dr_full_reg <= 1'b0;
         if (stop_done)
            dr_full_reg <= 1'b0;
         // empty shows only once the first bit is on the wire
         if (bit_smp && bit_cnt_reg == imw_pkg::BIT_FIRST)
            hold_reg <= 1'b0;
         if (data_rd)
            rdrf_reg <= 1'b0;
         // a host write in the flush cycle survives, set beats clear
         if (data_wr)
         begin
            dr_reg      <= data_wdata;
            dr_full_reg <= 1'b1;
         end
         if (rx_byte_done)
         begin
            dr_reg   <= {shift_reg[6:0], sda_s};
            rdrf_reg <= 1'b1;
         end
      end
   end

   // control and status bits; a set in the clear cycle wins
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         start_reg <= imw_pkg::FLAG_RST;
         stop_reg  <= imw_pkg::FLAG_RST;
         no_acknowledge_irq_flag_reg  <= imw_pkg::FLAG_RST;
         acknowledge_valid_flag_reg  <= imw_pkg::FLAG_RST;
         ack_reg   <= imw_pkg::FLAG_RST;
      end
      else
      begin
         if (start_done)
         begin
            start_reg <= 1'b0;
            no_acknowledge_irq_flag_reg  <= 1'b0;
            acknowledge_valid_flag_reg  <= 1'b0;
         end
         if (stop_done || (state_reg == imw_pkg::ST_IDLE && !start_reg))
         begin
            stop_reg <= 1'b0;
            no_acknowledge_irq_flag_reg <= 1'b0;
         end
         if (tx_ack_ok)
         begin
            ack_reg  <= 1'b1;
            acknowledge_valid_flag_reg <= 1'b1;
         end
         if (tx_nack)
         begin
            ack_reg  <= 1'b0;
            acknowledge_valid_flag_reg <= 1'b1;
            no_acknowledge_irq_flag_reg <= 1'b1;
         end
         if (rx_nak_done)
            no_acknowledge_irq_flag_reg <= 1'b1;
         if (start_req)
            start_reg <= 1'b1;
         if (stop_req)
            stop_reg <= 1'b1;
      end
   end

   // pin drive decoded from the next state so pins settle with it;
   // sda holds through the edge that pulls scl low, so no data change
   // meets a falling clock and reads as a stop on the far side
   always_comb
   begin
      scl_drv = 1'b1;
      sda_drv = 1'b0;
      case (state_next)
         imw_pkg::ST_IDLE, imw_pkg::ST_START_A, imw_pkg::ST_STOP_C:
            scl_drv = 1'b0;
         imw_pkg::ST_START_B, imw_pkg::ST_STOP_B:
         begin
            scl_drv = 1'b0;
            sda_drv = 1'b1;
         end
         imw_pkg::ST_STOP_A:
            sda_drv = 1'b1;
         imw_pkg::ST_BIT_L:
            sda_drv = !rx_reg && !shift_reg[7];
         imw_pkg::ST_BIT_H:
         begin
            scl_drv = 1'b0;
            sda_drv = !rx_reg && !shift_reg[7];
         end
         imw_pkg::ST_ACK_L:
            if (state_reg == imw_pkg::ST_RX_WAIT)
               sda_drv = !negative_ack_ctrl;
            else
               sda_drv = rx_reg && !nak_sent_reg;
         imw_pkg::ST_ACK_H:
         begin
            scl_drv = 1'b0;
            sda_drv = rx_reg && !nak_sent_reg;
         end
         default:
            scl_drv = 1'b1;
      endcase
      if (scl_drv && !scl_oe_reg)
         sda_drv = sda_oe_reg;
   end

   // registered pin enables keep glitches off the bus
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         scl_oe_reg <= imw_pkg::FLAG_RST;
         sda_oe_reg <= imw_pkg::FLAG_RST;
      end
      else
      begin
         scl_oe_reg <= scl_drv;
         sda_oe_reg <= sda_drv;
      end
   end

   assign scl_oe = scl_oe_reg;
   assign sda_oe = sda_oe_reg;
   assign scl_o  = imw_pkg::PIN_LOW;
   assign sda_o  = imw_pkg::PIN_LOW;

   // host-facing status
   assign transmit_data_empty_flag = !dr_full_reg && !hold_reg;
   assign irq = controller_enable_bit &&
                ((transmit_irq_enable && transmit_data_empty_flag) ||
                 rdrf_reg || no_acknowledge_irq_flag_reg);
   assign irq_status_register[imw_pkg::IST_TRANSMIT_DATA_EMPTY_FLAG] = transmit_data_empty_flag;
   assign irq_status_register[imw_pkg::IST_RDRF] = rdrf_reg;
   assign irq_status_register[imw_pkg::IST_NO_ACKNOWLEDGE_IRQ_FLAG] = no_acknowledge_irq_flag_reg;
   assign data_rdata              = dr_reg;
   assign receive_full_flag       = rdrf_reg;
   assign no_acknowledge_irq_flag = no_acknowledge_irq_flag_reg;
   assign acknowledge_valid_flag  = acknowledge_valid_flag_reg;
   assign ack_status              = ack_reg;
   assign start_bit               = start_reg;
   assign stop_bit                = stop_reg;
   assign bus_active              = (state_reg != imw_pkg::ST_IDLE);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence s_start_cond;
      state_reg == imw_pkg::ST_START_B && done;
   endsequence
   sequence s_bad_ack;
      tx_nack;
   endsequence

   AST_WR_FILLS: assert property (data_wr |=> !transmit_data_empty_flag)
      else $error("data write left empty flag set");
   AST_TX_IRQ: assert property (controller_enable_bit && transmit_irq_enable &&
      transmit_data_empty_flag |-> irq)
      else $error("empty data register without interrupt");
   AST_START_LOAD: assert property (s_start_cond |=> state_reg == imw_pkg::ST_LOAD
      && !start_reg)
      else $error("start condition not followed by load");
   AST_FIRST_BIT: assert property ($fell(hold_reg) |-> bit_cnt_reg == 3'h1
      && $past(bit_smp))
      else $error("transmit empty released off the first bit");
   AST_ACK_REC: assert property (tx_ack_ok |=> ack_reg && acknowledge_valid_flag_reg)
      else $error("acknowledge not recorded");
   AST_NACK_FLAGS: assert property (s_bad_ack |=> no_acknowledge_irq_flag_reg && acknowledge_valid_flag_reg && !ack_reg
      && (!dr_full_reg || $past(data_wr)) ##1 irq || !controller_enable_bit)
      else $error("no-ack flags wrong");
   AST_STOP_CLEAR: assert property (stop_done && !stop_req |=> !stop_reg && !no_acknowledge_irq_flag_reg
      && state_reg == imw_pkg::ST_IDLE)
      else $error("stop completion did not clear bits");
   AST_STOP_BOUNDARY: assert property (state_reg == imw_pkg::ST_STOP_A &&
      $past(state_reg) != imw_pkg::ST_STOP_A |-> $past(state_reg) inside
      {imw_pkg::ST_ACK_H, imw_pkg::ST_WAIT})
      else $error("stop cut into a byte");
   AST_RX_IRQ: assert property (rx_byte_done |=> rdrf_reg && state_reg ==
      imw_pkg::ST_RX_WAIT ##0 (!controller_enable_bit || irq))
      else $error("received byte without receive interrupt");
   AST_RX_ACK: assert property (state_reg == imw_pkg::ST_ACK_H && rx_reg &&
      !$stable(state_reg) |=> sda_oe == !nak_sent_reg)
      else $error("receive acknowledge bit wrong");
   AST_EIGHT_BITS: assert property (state_reg == imw_pkg::ST_ACK_L &&
      $past(state_reg) == imw_pkg::ST_BIT_H |-> bit_cnt_reg == imw_pkg::BIT_FIRST)
      else $error("acknowledge bit not after eight data bits");
   AST_TEN_BIT: assert property ($rose(addr10_reg) |-> shift_reg[7:3] ==
      imw_pkg::TEN_BIT_PREFIX)
      else $error("ten-bit flag without prefix in the shifter");

endmodule
`default_nettype wire

// File: testbench/imw_slave.sv
// behavioural remote slave: takes bytes, acks them, serves bytes on reads
// assumes wired-and scl and sda levels with pull-ups made in the bench
`timescale 1ns/10ps
`default_nettype none
module imw_slave (
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic ack_en,
   input  wire logic [31:0] stretch_ns,
   output logic      scl_pull,
   output logic      sda_pull
);
   logic [7:0] sh      = 8'h00;
   logic [7:0] tx_byte = 8'hA5;
   logic [1:0] mack    = 2'h0;
   logic       rd_mode = 1'b0;
   logic       first   = 1'b0;
   int         bitn    = 0;
   int         n_stop  = 0;
   logic [7:0] rx_q[$];

   initial scl_pull = 1'b0;
   initial sda_pull = 1'b0;

   // start and stop: sda moves while scl is high
   always @(negedge sda)
      if (scl)
      begin
         bitn = 0;
         first = 1'b1;
         rd_mode = 1'b0;
         mack = 2'h0;
      end
   always @(posedge sda)
      if (scl)
      begin
         bitn = 0;
         n_stop++;
      end

   // rising scl: eight bits then the acknowledge slot
   always @(posedge scl)
   begin
      if (bitn < 8)
         sh = {sh[6:0], sda};
      else if (rd_mode)
         mack = {mack[0], sda};
      bitn = (bitn + 1) % 9;
   end

   // falling scl: change sda only while the clock is low
   always @(negedge scl)
   begin
      sda_pull = 1'b0;
      if (rd_mode && bitn == 0 && mack[0])
         rd_mode = 1'b0;
      if (rd_mode && bitn < 8)
         sda_pull = !tx_byte[7 - bitn];
      else if (rd_mode)
         tx_byte = tx_byte + 8'h11;
      else if (bitn == 8)
      begin
         rx_q.push_back(sh);
         sda_pull = ack_en;
         rd_mode = first && sh[0];
         first = 1'b0;
      end
   end

   // slow slave: hold scl low a while after each fall
   always @(negedge scl)
      if (stretch_ns > 0)
      begin
         scl_pull = 1'b1;
         #(stretch_ns);
         scl_pull = 1'b0;
      end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// bench: 10-bit write, address no-ack, slow two-byte 7-bit read, data no-ack
// assumes imw_slave on a pulled-up wired-and bus; one bit takes ~1000 cycles
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam logic [7:0] ROWS [3] = '{8'hF2, 8'h5A, 8'hC3};
   logic       sys_clk = 1'b0;
   logic       resetn = 1'b0;
   logic       enable = 1'b0;
   logic       tx_irq_en = 1'b0;
   logic       start_req = 1'b0;
   logic       stop_req = 1'b0;
   logic       nack_ctl = 1'b0;
   logic       data_wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic       data_rd = 1'b0;
   logic       ack_en = 1'b1;
   int         stretch = 0;
   int         n_fail = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   int         ns = 0;
   logic [7:0] rdata;
   logic       start_bit, stop_bit, tx_empty, rx_full, nack_flag, ack_valid, ack, busy, irq;
   logic [2:0] ist;
   logic       scl_oe, sda_oe, scl_pull, sda_pull;
   // open-drain wires with pull-ups
   wire logic  scl = !(scl_oe || scl_pull);
   wire logic  sda = !(sda_oe || sda_pull);

   imw_master i_imw_master (.sys_clk(sys_clk), .resetn(resetn),
      .controller_enable_bit(enable), .transmit_irq_enable(tx_irq_en),
      .start_req(start_req), .stop_req(stop_req), .negative_ack_ctrl(nack_ctl),
      .data_wr(data_wr), .data_wdata(wdata), .data_rd(data_rd), .data_rdata(rdata),
      .start_bit(start_bit), .stop_bit(stop_bit), .transmit_data_empty_flag(tx_empty),
      .receive_full_flag(rx_full), .no_acknowledge_irq_flag(nack_flag),
      .acknowledge_valid_flag(ack_valid), .ack_status(ack), .bus_active(busy),
      .irq_status_register(ist), .irq(irq), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
   imw_slave i_imw_slave (.scl(scl), .sda(sda), .ack_en(ack_en), .stretch_ns(stretch),
      .scl_pull(scl_pull), .sda_pull(sda_pull));

   always #5 sys_clk = ~sys_clk;

   // hang guard, above the ~94k cycles the run needs
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 100000)
      begin
         n_fail++;
         finish_test();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
         n_fail++;
      end
   endtask

   task automatic wr(input logic [7:0] b);
      data_wr = 1'b1;
      wdata = b;
      tick(1);
      data_wr = 1'b0;
   endtask

   // one-cycle start (st=1) or stop (st=0) strobe
   task automatic req(input logic st);
      start_req = st;
      stop_req = !st;
      tick(1);
      start_req = 1'b0;
      stop_req = 1'b0;
   endtask

   // k: 0 empty, 1 full, 2 no-ack, 3 idle; a long wait counts as a mismatch
   task automatic wait_on(input int k);
      logic [3:0] f;
      for (int n = 0; n < 40000; n++)
      begin
         f = {!busy, nack_flag, rx_full, tx_empty};
         if (f[k] === 1'b1)
            return;
         tick(1);
      end
      chk(8'h00, 8'h01, "wait timed out");
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      tick(4);
      resetn = 1'b1;
      ns = i_imw_slave.n_stop;
      chk(8'({irq, sda_oe, scl_oe, nack_flag, ack_valid}), 8'h00, "reset outputs");
      chk(8'(ist), 8'h01, "status word at reset");
      enable = 1'b1;
      tx_irq_en = 1'b1;
      tick(2);
      chk(8'(irq), 8'h01, "irq on empty register");
      tx_irq_en = 1'b0;
      tick(2);
      chk(8'({irq, tx_empty}), 8'h01, "empty flag without irq");
      // 10-bit write: rows fed one per empty flag, all must reach the wire
      tx_irq_en = 1'b1;
      wr(ROWS[0]);
      req(1'b1);
      for (int i = 1; i < 4; i++)
      begin
         wait_on(0);
         chk(8'(i_imw_slave.bitn), 8'h01, "empty after first bit");
         if (i < 3)
            wr(ROWS[i]);
      end
      req(1'b0);
      wait_on(3);
      for (int i = 0; i < 3; i++)
         chk(i_imw_slave.rx_q[i], ROWS[i], "byte on wire");
      chk(8'({ack, ack_valid, stop_bit}), 8'h06, "acked write");
      chk(8'(i_imw_slave.n_stop - ns), 8'h01, "stop after byte");
      // first address byte refused by the slave
      ack_en = 1'b0;
      wr(8'hF4);
      req(1'b1);
      wait_on(0);
      wr(8'h33);
      wait_on(2);
      chk(8'({ack_valid, ack}), 8'h02, "address no-ack");
      tx_irq_en = 1'b0;
      req(1'b0);
      wait_on(3);
      chk(8'({nack_flag, stop_bit, tx_empty}), 8'h01, "flushed");
      chk(8'(i_imw_slave.n_stop - ns), 8'h02, "stop after no-ack");
      // 7-bit read of two bytes from a slave that stretches scl
      ack_en = 1'b1;
      stretch = 5500;
      wr(8'hA1);
      req(1'b1);
      for (int i = 0; i < 2; i++)
      begin
         wait_on(1);
         chk(rdata, (i == 1) ? 8'hB6 : 8'hA5, "read byte");
         nack_ctl = i[0];
         data_rd = 1'b1;
         tick(1);
         data_rd = 1'b0;
      end
      wait_on(2);
      chk(8'(i_imw_slave.mack), 8'h01, "ack then no-ack");
      req(1'b0);
      wait_on(3);
      chk(8'(i_imw_slave.n_stop - ns), 8'h03, "stop after read");
      // 7-bit write whose data byte is refused: flushed, halted until stop
      stretch = 0;
      wr(8'h50);
      req(1'b1);
      wait_on(0);
      wr(8'h77);
      wait_on(0);
      ack_en = 1'b0;
      wr(8'h88);
      wait_on(2);
      wr(8'h99);
      tick(1200);
      chk(8'({ack_valid, ack, busy}), 8'h05, "halted on data no-ack");
      req(1'b0);
      wait_on(3);
      chk(8'(i_imw_slave.rx_q.size()), 8'h07, "nothing after data no-ack");
      chk(8'(i_imw_slave.n_stop - ns), 8'h04, "stop after data no-ack");
      finish_test();
   end
endmodule
`default_nettype wire
